// file: cbc_defines.vh
// Purpose: Shared constants of the clocked serial bus control block.
// Assumes: A 10 MHz system clock; register selectors are local to this block.
// Notes: Included by the cbc_sck_gen and cbc_ctrl design files of the block.
`ifndef CBC_DEFINES_VH
`define CBC_DEFINES_VH

// Register selectors on the CPU access port.
`define CBC_SEL_MODE 2'h0
`define CBC_SEL_BUS 2'h1
`define CBC_SEL_SHIFT 2'h2
`define CBC_SEL_ADDR 2'h3

// Bit positions in the serial mode register.
`define CBC_MODE_ENABLE 3'h7
`define CBC_MODE_MATCH 3'h6
`define CBC_MODE_WAKE 3'h5
`define CBC_MODE_SELECT 3'h3
`define CBC_MODE_CLKSRC 3'h1

// Bit positions in the bus control register.
`define CBC_BUS_BUSY_EN 3'h7
`define CBC_BUS_ACK_DET 3'h6
`define CBC_BUS_ACK_AUTO 3'h5
`define CBC_BUS_ACK_TRIG 3'h4
`define CBC_BUS_CMD_DET 3'h3
`define CBC_BUS_REL_DET 3'h2
`define CBC_BUS_CMD_TRIG 3'h1
`define CBC_BUS_REL_TRIG 3'h0

// Reset values.
`define CBC_MODE_RESET 8'h00
`define CBC_BUS_RESET 8'h00

// Fixed upper part of the own address.
`define CBC_ADDR_HIGH 5'h18

// Internal serial clock is the system clock divided by this ratio.
`define CBC_SCK_DIV 16
`define CBC_SCK_HALF (`CBC_SCK_DIV / 2)

// Number of data bits in one transfer.
`define CBC_XFER_BITS 4'h8

`endif

// file: cbc_sync.v
// Purpose: Two-stage synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module cbc_sync
#(
  parameter WIDTH = 3
)
(
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // Both stages reset high, the idle level of the bus lines.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end
    else if (ce)
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// file: cbc_sck_gen.v
// Purpose: Internal serial clock generator for the clock-output case.
// Assumes: run is a level from logic on clk_sys.
// Notes: The clock idles high and only stops after a high phase is reached.
`timescale 1ns/1ps
`include "cbc_defines.vh"
module cbc_sck_gen
#(
  parameter HALF = `CBC_SCK_HALF
)
(
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire run,
  output reg sck_level
);

  localparam integer HALF_LAST = HALF - 1;

  reg [7:0] div_cnt;

  // Toggles the clock every half period while running or while low, so a cycle never ends short.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt <= 8'h00;
      sck_level <= 1'b1;
    end
    else if (ce)
    begin
      if (run || !sck_level)
      begin
        if ({24'h000000, div_cnt} == HALF_LAST)
        begin
          div_cnt <= 8'h00;
          sck_level <= ~sck_level;
        end
        else
        begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
      else
      begin
        div_cnt <= 8'h00;
      end
    end
  end

endmodule

// file: cbc_ctrl.v
// Purpose: Control and status logic of an 8-bit clocked serial interface with a two-wire bus mode.
// Assumes: CPU accesses are one-cycle strobes on clk_sys; pins are asynchronous.
// Notes on behaviour
// - Wake-up off: interrupt flag sets after every 8-bit transfer in any mode.
// - Wake-up on, bus mode: flag only on matching address; data pin floats.
// - Wake-up set while busy keeps busy; busy ends at next falling clock.
// - Address match flag follows equality of own address and shift register.
// - Match flag valid outside transfers; byte writes to it are ignored.
// - Enable low halts shifting, clears counter, keeps flag, pins act as ports.
// - Mode: enable low halted, else select picks 3-wire or bus mode.
// - Clock pin: input or high output halted; input or idle-high clock enabled.
// - Bus control register accepts single-bit writes only; nibble, byte ignored.
// - Reset clears the whole bus control register.
// - In 3-wire mode only the two latch triggers of bus control work.
// - Release trigger sets the output latch, then reads back zero.
// - Command trigger clears the output latch, then reads back zero.
// - Release flag sets on release; clears on start, reset, disable, address miss.
// - Command flag sets on command; clears on start, release, reset, disable.
// - Acknowledge trigger after transfer drives ack next clock then self-clears.
// - Auto-ack off means no ack; set before end acks on ninth clock.
// - Auto-ack set after end acks on the clock following the write.
`timescale 1ns/1ps
`include "cbc_defines.vh"
module cbc_ctrl
(
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire [1:0] cpu_sel,
  input wire cpu_wr_byte,
  input wire cpu_wr_nib,
  input wire cpu_wr_bit,
  input wire [2:0] cpu_bit,
  input wire [7:0] cpu_wdata,
  input wire cpu_rd,
  output reg [7:0] cpu_rdata,
  input wire irq_clear,
  output reg serial_irq_flag,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  input wire sd_in,
  output reg sd_out,
  output reg sd_oe,
  input wire si_in
);

  reg serial_enable;
  reg mode_select_bit;
  reg clock_source_bit;
  reg wake_on_address;
  reg address_match_flag;
  reg [7:0] shift_reg;
  reg [2:0] own_addr_low;
  reg release_detected;
  reg command_detected;
  reg ack_trigger;
  reg ack_auto_enable;
  reg so_latch;
  reg [3:0] bit_cnt;
  reg xfer_active;
  reg ack_pend;
  reg ack_drive;
  reg busy_drive;
  reg busy_rel;
  reg sck_prev;
  reg sd_prev;
  reg [7:0] next_shift;
  reg next_level;
  wire [2:0] pin_sync;
  wire sck_s;
  wire sd_s;
  wire si_s;
  wire gen_sck;
  wire gen_run;
  wire sck_sel;
  wire sck_rise;
  wire sck_fall;
  wire bus_mode;
  wire wire3_mode;
  wire [7:0] own_address_reg;
  wire xfer_start;
  wire xfer_end;
  wire rel_seen;
  wire cmd_seen;
  wire addr_hit;
  wire is_address;
  wire [7:0] mode_rd;
  wire [7:0] bus_rd;

  // Single-bit write decode for one register and bit position.
  function bit_wr;
    input wr;
    input [1:0] sel;
    input [2:0] idx;
    input [1:0] want_sel;
    input [2:0] want_idx;
    begin
      bit_wr = wr && (sel == want_sel) && (idx == want_idx);
    end
  endfunction

  cbc_sync #(.WIDTH(3)) u_sync
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .async_in({sck_in, sd_in, si_in}),
    .sync_out(pin_sync)
  );

  assign sck_s = pin_sync[2];
  assign sd_s = pin_sync[1];
  assign si_s = pin_sync[0];

  // Internal clock runs only for a transfer or an acknowledge in the clock-output case.
  assign gen_run = serial_enable && clock_source_bit && (xfer_active || ack_pend || ack_drive);

  cbc_sck_gen #(.HALF(`CBC_SCK_HALF)) u_gen
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .run(gen_run),
    .sck_level(gen_sck)
  );

  // Mode decode and serial clock selection.
  assign bus_mode = serial_enable && mode_select_bit;
  assign wire3_mode = serial_enable && !mode_select_bit;
  assign sck_sel = clock_source_bit ? gen_sck : sck_s;
  assign sck_rise = sck_sel && !sck_prev && serial_enable;
  assign sck_fall = !sck_sel && sck_prev && serial_enable;
  assign own_address_reg = {`CBC_ADDR_HIGH, own_addr_low};

  // A transfer starts on a shift register write while enabled and the clock is high.
  assign xfer_start = ce && cpu_wr_byte && (cpu_sel == `CBC_SEL_SHIFT) && serial_enable && sck_sel;
  assign xfer_end = xfer_active && sck_rise && (bit_cnt == (`CBC_XFER_BITS - 4'h1));

  // Bus release is a rising data line and a command a falling one, both while the clock is high.
  // They are also seen while a slave waits with a loaded shift register, so the address after a release is caught.
  assign rel_seen = bus_mode && sck_s && sd_s && !sd_prev;
  assign cmd_seen = bus_mode && sck_s && !sd_s && sd_prev;

  // The first byte after a release without a command is an address.
  assign is_address = bus_mode && release_detected && !command_detected;
  assign addr_hit = (next_shift == own_address_reg);

  // Next shift value and the bus level the device wants.
  always @*
  begin
    next_shift = {shift_reg[6:0], (bus_mode ? sd_s : si_s)};
    next_level = xfer_active ? shift_reg[7] : so_latch;
  end

  // Read views; the two latch trigger bits and the omitted bits read as zero.
  assign mode_rd = {serial_enable, address_match_flag, wake_on_address, 1'b0, mode_select_bit, 1'b0,
                    clock_source_bit, 1'b0};
  assign bus_rd = {1'b0, 1'b0, ack_auto_enable, ack_trigger, command_detected, release_detected,
                   1'b0, 1'b0};

  // Serial mode register.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_enable <= 1'b0;
      mode_select_bit <= 1'b0;
      clock_source_bit <= 1'b0;
      wake_on_address <= 1'b0;
    end
    else if (ce)
    begin
      if (cpu_wr_byte && (cpu_sel == `CBC_SEL_MODE))
      begin
        serial_enable <= cpu_wdata[`CBC_MODE_ENABLE];
        wake_on_address <= cpu_wdata[`CBC_MODE_WAKE];
        mode_select_bit <= cpu_wdata[`CBC_MODE_SELECT];
        clock_source_bit <= cpu_wdata[`CBC_MODE_CLKSRC];
      end
      else if (cpu_wr_nib && (cpu_sel == `CBC_SEL_MODE))
      begin
        mode_select_bit <= cpu_wdata[`CBC_MODE_SELECT];
        clock_source_bit <= cpu_wdata[`CBC_MODE_CLKSRC];
      end
      else
      begin
        if (bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_MODE, `CBC_MODE_ENABLE))
          serial_enable <= cpu_wdata[0];
        if (bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_MODE, `CBC_MODE_WAKE))
          wake_on_address <= cpu_wdata[0];
      end
    end
  end

  // Match flag compares continuously; it is never written by software.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      address_match_flag <= 1'b0;
    else if (ce)
      address_match_flag <= (shift_reg == own_address_reg);
  end

  // Own address low bits and the shift register with its bit counter.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      own_addr_low <= 3'h0;
      shift_reg <= 8'h00;
      bit_cnt <= 4'h0;
      xfer_active <= 1'b0;
    end
    else if (ce)
    begin
      if (cpu_wr_byte && (cpu_sel == `CBC_SEL_ADDR))
        own_addr_low <= cpu_wdata[2:0];
      if (!serial_enable)
      begin
        bit_cnt <= 4'h0;
        xfer_active <= 1'b0;
        if (cpu_wr_byte && (cpu_sel == `CBC_SEL_SHIFT))
          shift_reg <= cpu_wdata;
      end
      else if (xfer_start)
      begin
        shift_reg <= cpu_wdata;
        bit_cnt <= 4'h0;
        xfer_active <= 1'b1;
      end
      else if (xfer_active && (rel_seen || cmd_seen))
      begin
        bit_cnt <= 4'h0; // A release or command condition restarts the byte count.
      end
      else if (xfer_active && sck_rise)
      begin
        shift_reg <= next_shift;
        bit_cnt <= bit_cnt + 4'h1;
        if (xfer_end)
          xfer_active <= 1'b0;
      end
    end
  end

  // Interrupt flag; an event in the clearing cycle wins.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      serial_irq_flag <= 1'b0;
    else if (ce)
    begin
      if (xfer_end && (!wake_on_address || !bus_mode))
        serial_irq_flag <= 1'b1;
      else if (xfer_end && is_address && addr_hit)
        serial_irq_flag <= 1'b1;
      else if (irq_clear)
        serial_irq_flag <= 1'b0;
    end
  end

  // Output latch, detection flags and acknowledge control of the bus control register.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      so_latch <= 1'b1;
      release_detected <= 1'b0;
      command_detected <= 1'b0;
      ack_trigger <= 1'b0;
      ack_auto_enable <= 1'b0;
      ack_pend <= 1'b0;
      ack_drive <= 1'b0;
    end
    else if (ce)
    begin
      // Latch: set after the eighth clock in bus mode, overridden by a trigger write.
      if (xfer_end && bus_mode)
        so_latch <= 1'b1;
      if (bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_BUS, `CBC_BUS_REL_TRIG) && cpu_wdata[0])
        so_latch <= 1'b1;
      else if (bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_BUS, `CBC_BUS_CMD_TRIG) && cpu_wdata[0])
        so_latch <= 1'b0;
      // Release flag: clears first, a detection in the same cycle wins.
      if (!serial_enable || xfer_start || (xfer_end && is_address && !addr_hit))
        release_detected <= 1'b0;
      if (rel_seen)
        release_detected <= 1'b1;
      // Command flag is also cleared by a release.
      if (!serial_enable || xfer_start || rel_seen)
        command_detected <= 1'b0;
      else if (cmd_seen)
        command_detected <= 1'b1;
      // Auto acknowledge enable is a plain single-bit register.
      if (bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_BUS, `CBC_BUS_ACK_AUTO))
        ack_auto_enable <= cpu_wdata[0];
      // Software can only set the acknowledge trigger; only hardware clears it.
      if (bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_BUS, `CBC_BUS_ACK_TRIG) && cpu_wdata[0] && bus_mode)
        ack_trigger <= 1'b1;
      else if (ack_drive && sck_fall)
        ack_trigger <= 1'b0;
      // Acknowledge request: at transfer end with auto enable, or on a later write.
      if (!bus_mode)
        ack_pend <= 1'b0;
      else if (xfer_end && ack_auto_enable)
        ack_pend <= 1'b1;
      else if (!xfer_active && bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_BUS, `CBC_BUS_ACK_AUTO)
               && cpu_wdata[0] && !ack_auto_enable)
        ack_pend <= 1'b1;
      else if (!xfer_active && bit_wr(cpu_wr_bit, cpu_sel, cpu_bit, `CBC_SEL_BUS, `CBC_BUS_ACK_TRIG)
               && cpu_wdata[0])
        ack_pend <= 1'b1;
      else if (ack_pend && sck_fall)
        ack_pend <= 1'b0;
      // Acknowledge is driven from one falling clock edge to the next: the ninth clock.
      if (!bus_mode)
        ack_drive <= 1'b0;
      else if (ack_pend && sck_fall)
        ack_drive <= 1'b1;
      else if (ack_drive && sck_fall)
        ack_drive <= 1'b0;
    end
  end

  // Busy follows the acknowledge of a slave and is released at a falling clock after a request.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_drive <= 1'b0;
      busy_rel <= 1'b0;
    end
    else if (ce)
    begin
      if (!bus_mode)
      begin
        busy_drive <= 1'b0;
        busy_rel <= 1'b0;
      end
      else
      begin
        if (ack_drive && sck_fall && !clock_source_bit)
          busy_drive <= 1'b1;
        else if (busy_rel && sck_fall && !wake_on_address)
          busy_drive <= 1'b0;
        if (busy_drive && xfer_start)
          busy_rel <= 1'b1;
        else if (busy_rel && sck_fall && !wake_on_address)
          busy_rel <= 1'b0;
      end
    end
  end

  // Edge history of the selected clock and the data line.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_prev <= 1'b1;
      sd_prev <= 1'b1;
    end
    else if (ce)
    begin
      sck_prev <= sck_sel;
      sd_prev <= sd_s;
    end
  end

  // Registered pin drivers and read data.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
      sd_out <= 1'b0;
      sd_oe <= 1'b0;
      cpu_rdata <= 8'h00;
    end
    else if (ce)
    begin
      sck_out <= serial_enable ? gen_sck : 1'b1;
      sck_oe <= clock_source_bit;
      if (wire3_mode)
      begin
        sd_out <= next_level;
        sd_oe <= 1'b1;
      end
      else if (bus_mode && !wake_on_address)
      begin
        sd_out <= 1'b0;
        sd_oe <= ack_drive || busy_drive || !next_level;
      end
      else
      begin
        sd_out <= 1'b0;
        sd_oe <= 1'b0;
      end
      if (cpu_rd)
      begin
        case (cpu_sel)
          `CBC_SEL_MODE: cpu_rdata <= mode_rd;
          `CBC_SEL_BUS: cpu_rdata <= cpu_wr_bit ? 8'h00 : bus_rd;
          `CBC_SEL_SHIFT: cpu_rdata <= shift_reg;
          default: cpu_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// file: cbc_ctrl_properties.sv
// Purpose: Port-level properties of cbc_ctrl.
// Assumes: The internal clock generator runs with a half period of 8.
// Notes: Bound to every cbc_ctrl instance.
`timescale 1ns/1ps
module cbc_ctrl_props
(
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire [1:0] cpu_sel,
  input wire cpu_wr_byte,
  input wire cpu_wr_nib,
  input wire cpu_wr_bit,
  input wire [2:0] cpu_bit,
  input wire [7:0] cpu_wdata,
  input wire cpu_rd,
  input wire [7:0] cpu_rdata,
  input wire irq_clear,
  input wire serial_irq_flag,
  input wire sck_in,
  input wire sck_out,
  input wire sck_oe,
  input wire sd_in,
  input wire sd_out,
  input wire sd_oe,
  input wire si_in
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Register reads show fixed zero fields.
  trig_read_zero_a: assert property (cpu_rd && cpu_sel == 2'h1 |=> (cpu_rdata & 8'hc3) == 8'h00)
    else $error("bus control fixed bits read nonzero");
  mode_read_fmt_a: assert property (cpu_rd && cpu_sel == 2'h0 |=> (cpu_rdata & 8'h15) == 8'h00)
    else $error("mode register unused bits read nonzero");
  // The flag only falls when software clears it.
  irq_hold_a: assert property (serial_irq_flag && !irq_clear |=> serial_irq_flag)
    else $error("interrupt flag lost without a clear");
  // The driven clock has a low phase of eight cycles and starts high.
  clk_low_phase_a: assert property (sck_oe && $fell(sck_out) |=> !sck_out [*7] ##1 sck_out)
    else $error("clock low phase has the wrong length");
  clk_start_high_a: assert property ($rose(sck_oe) |-> sck_out)
    else $error("clock output did not start high");
  irq_clk_high_a: assert property ($rose(serial_irq_flag) && sck_oe |-> sck_out)
    else $error("transfer ended while the clock was low");
  // The latch triggers reach the data pin two cycles later.
  release_line_a: assert property (cpu_wr_bit && cpu_sel == 2'h1 && cpu_bit == 3'h0 && cpu_wdata[0]
    |-> ##2 !(sd_oe && !sd_out))
    else $error("release trigger left the line low");
  command_line_a: assert property (cpu_wr_bit && cpu_sel == 2'h1 && cpu_bit == 3'h1 && cpu_wdata[0]
    |-> ##2 !(sd_oe && sd_out))
    else $error("command trigger left the line high");
  // Main scenarios.
  cover property ($rose(serial_irq_flag));
  cover property (sck_oe && $fell(sck_out));
  cover property (sd_oe && !sd_out);
endmodule

bind cbc_ctrl cbc_ctrl_props cbc_ctrl_props_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .cpu_sel(cpu_sel),
  .cpu_wr_byte(cpu_wr_byte), .cpu_wr_nib(cpu_wr_nib), .cpu_wr_bit(cpu_wr_bit), .cpu_bit(cpu_bit),
  .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .irq_clear(irq_clear),
  .serial_irq_flag(serial_irq_flag), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
  .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .si_in(si_in));

// file: cbc_bus_peer.sv
// Purpose: Far-side bus device that drives the serial clock and pulls the data line.
// Assumes: The data line has a pull-up; the clock idles high between frames.
// Notes: Half period 400 ns gives an 800 ns serial clock.
`timescale 1ns/1ps
module cbc_bus_peer
(
  output reg sck,
  output reg sd_low,
  output reg si
);
  localparam integer half = 400;
  integer i;
  // Idle lines at time zero.
  initial
  begin
    sck = 1'b1;
    sd_low = 1'b0;
    si = 1'b1;
  end
  // Data rises while the clock is high, a bus release.
  task rel_cond;
  begin
    sck = 1'b0;
    #half sd_low = 1'b1;
    #half sck = 1'b1;
    #half sd_low = 1'b0;
    #half;
  end
  endtask
  // Data falls while the clock is high, a command; freed under a low clock.
  task cmd_cond;
  begin
    sd_low = 1'b1;
    #half sck = 1'b0;
    #half sd_low = 1'b0;
    #half sck = 1'b1;
    #half;
  end
  endtask
  // Eight bits, first bit the most significant, changed while the clock is low.
  task send(input [7:0] d);
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      sck = 1'b0;
      sd_low = ~d[i];
      si = d[i];
      #half sck = 1'b1;
      #half;
    end
    sd_low = 1'b0;
  end
  endtask
  // One extra clock pulse.
  task pulse;
  begin
    sck = 1'b0;
    #half sck = 1'b1;
    #half;
  end
  endtask
endmodule

// file: cbc_ctrl_bench.sv
// Purpose: Self-checking bench for cbc_ctrl.
// Assumes: A pull-up holds the data line; ce is held high.
// Notes: The peer model supplies the external clock and data.
`timescale 1ns/1ps
module cbc_ctrl_bench;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg [1:0] cpu_sel = 2'h0;
  reg cpu_wr_byte = 1'b0;
  reg cpu_wr_nib = 1'b0;
  reg cpu_wr_bit = 1'b0;
  reg [2:0] cpu_bit = 3'h0;
  reg [7:0] cpu_wdata = 8'h00;
  reg cpu_rd = 1'b0;
  reg irq_clear = 1'b0;
  reg [7:0] rv;
  reg oe_seen = 1'b0;
  reg watch = 1'b0;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer i;
  wire [7:0] cpu_rdata;
  wire serial_irq_flag, sck_out, sck_oe, sd_out, sd_oe, peer_sck, peer_low, peer_si;
  wire sck_in = sck_oe ? sck_out : peer_sck;
  wire sd_in = ~((sd_oe & ~sd_out) | peer_low);
  localparam [1:0] by = 2'h0;
  localparam [1:0] nb = 2'h1;
  localparam [1:0] bt = 2'h2;
  always #50 clk_sys = ~clk_sys;
  // Remembers any drive of the data line while watched.
  always @(posedge clk_sys)
    if (watch && sd_oe === 1'b1)
      oe_seen <= 1'b1;
  cbc_ctrl cbc_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .cpu_sel(cpu_sel),
    .cpu_wr_byte(cpu_wr_byte), .cpu_wr_nib(cpu_wr_nib), .cpu_wr_bit(cpu_wr_bit), .cpu_bit(cpu_bit),
    .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .irq_clear(irq_clear),
    .serial_irq_flag(serial_irq_flag), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .si_in(peer_si));
  cbc_bus_peer cbc_bus_peer_inst (.sck(peer_sck), .sd_low(peer_low), .si(peer_si));
  // Prints the counts and the verdict, then stops.
  task conclude;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // One write strobe of the given kind.
  task w(input [1:0] s, input [1:0] k, input [2:0] b, input [7:0] d);
  begin
    @(negedge clk_sys);
    cpu_sel = s;
    cpu_bit = b;
    cpu_wdata = d;
    cpu_wr_byte = (k == by);
    cpu_wr_nib = (k == nb);
    cpu_wr_bit = (k == bt);
    @(negedge clk_sys);
    {cpu_wr_byte, cpu_wr_nib, cpu_wr_bit} = 3'h0;
  end
  endtask
  task rd(input [1:0] s);
  begin
    @(negedge clk_sys);
    cpu_sel = s;
    cpu_rd = 1'b1;
    @(negedge clk_sys);
    cpu_rd = 1'b0;
    @(negedge clk_sys);
    rv = cpu_rdata;
  end
  endtask
  // Waits a bounded time for the interrupt flag.
  task wirq(input integer n);
  begin
    i = 0;
    while (i < n && serial_irq_flag !== 1'b1)
    begin
      @(negedge clk_sys);
      i = i + 1;
    end
    chk({7'h0, serial_irq_flag}, 8'h01);
    if (serial_irq_flag !== 1'b1)
      conclude;
  end
  endtask
  task clr;
  begin
    @(negedge clk_sys);
    irq_clear = 1'b1;
    @(negedge clk_sys);
    irq_clear = 1'b0;
    @(negedge clk_sys);
    chk({7'h0, serial_irq_flag}, 8'h00);
  end
  endtask
  // Main sequence.
  initial
  begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    rd(2'h1);
    chk(rv, 8'h00);
    w(2'h1, by, 3'h0, 8'hff);
    w(2'h1, nb, 3'h0, 8'hff);
    rd(2'h1);
    chk(rv, 8'h00);
    w(2'h1, bt, 3'h5, 8'h01);
    rd(2'h1);
    chk(rv, 8'h20);
    w(2'h1, bt, 3'h5, 8'h00);
    w(2'h3, by, 3'h0, 8'h05);
    w(2'h2, by, 3'h0, 8'hc5);
    rd(2'h0);
    chk(rv, 8'h40);
    w(2'h2, by, 3'h0, 8'hc4);
    w(2'h0, by, 3'h0, 8'h40);
    rd(2'h0);
    chk(rv, 8'h00);
    w(2'h0, by, 3'h0, 8'h80);
    w(2'h1, bt, 3'h0, 8'h01);
    @(negedge clk_sys);
    chk({6'h0, sd_oe, sd_out}, 8'h03);
    rd(2'h1);
    chk(rv, 8'h00);
    w(2'h1, bt, 3'h1, 8'h01);
    @(negedge clk_sys);
    chk({6'h0, sd_oe, sd_out}, 8'h02);
    w(2'h1, bt, 3'h0, 8'h01);
    @(negedge clk_sys);
    chk({6'h0, sd_oe, sd_out}, 8'h03);
    w(2'h0, by, 3'h0, 8'h82);
    rd(2'h0);
    chk(rv & 8'hbf, 8'h82);
    w(2'h2, by, 3'h0, 8'h3c);
    wirq(300);
    rd(2'h2);
    chk(rv, 8'hff);
    w(2'h0, bt, 3'h7, 8'h00);
    chk({7'h0, serial_irq_flag}, 8'h01);
    clr;
    w(2'h0, by, 3'h0, 8'h88);
    w(2'h1, bt, 3'h0, 8'h01);
    cbc_bus_peer_inst.rel_cond;
    rd(2'h1);
    chk(rv, 8'h04);
    cbc_bus_peer_inst.cmd_cond;
    rd(2'h1);
    chk(rv, 8'h0c);
    cbc_bus_peer_inst.rel_cond;
    rd(2'h1);
    chk(rv, 8'h04);
    w(2'h2, by, 3'h0, 8'hff);
    rd(2'h1);
    chk(rv, 8'h00);
    cbc_bus_peer_inst.send(8'ha5);
    wirq(50);
    rd(2'h2);
    chk(rv, 8'ha5);
    clr;
    chk({7'h0, sd_in}, 8'h01);
    w(2'h0, bt, 3'h5, 8'h01);
    w(2'h2, by, 3'h0, 8'hff);
    watch = 1'b1;
    cbc_bus_peer_inst.send(8'ha5);
    repeat (20) @(negedge clk_sys);
    watch = 1'b0;
    chk({6'h0, oe_seen, serial_irq_flag}, 8'h00);
    w(2'h2, by, 3'h0, 8'hff);
    cbc_bus_peer_inst.rel_cond;
    cbc_bus_peer_inst.send(8'hc5);
    wirq(50);
    rd(2'h1);
    chk(rv, 8'h04);
    clr;
    w(2'h2, by, 3'h0, 8'hff);
    cbc_bus_peer_inst.rel_cond;
    cbc_bus_peer_inst.send(8'hc4);
    rd(2'h1);
    chk(rv, 8'h00);
    chk({7'h0, serial_irq_flag}, 8'h00);
    w(2'h0, bt, 3'h5, 8'h00);
    w(2'h1, bt, 3'h4, 8'h01);
    w(2'h1, bt, 3'h4, 8'h00);
    rd(2'h1);
    chk(rv & 8'h10, 8'h10);
    watch = 1'b1;
    cbc_bus_peer_inst.pulse;
    cbc_bus_peer_inst.pulse;
    watch = 1'b0;
    chk({7'h0, oe_seen}, 8'h01);
    rd(2'h1);
    chk(rv & 8'h10, 8'h00);
    conclude;
  end
endmodule
